// File: include/fcc_params.svh
// register offsets, field positions, reset values and counts of the clock controller
// assumes a 32-bit classic Wishbone with byte addresses, one register per word
`ifndef FCC_PARAMS_SVH
`define FCC_PARAMS_SVH
`define FCC_OFS_FREQ_CTRL 4'h0
`define FCC_OFS_STATUS 4'h4
`define FCC_OFS_SETTLE_CFG 4'h8
`define FCC_FREQ_CTRL_RESET 16'h0102
`define FCC_FREQ_CTRL_WMASK 16'he7ff
`define FCC_SETTLE_CFG_RESET 11'h000
`define FCC_BIT_SLEEP_DIV 9
`define FCC_BIT_CLK_OUT_EN 8
`define FCC_BIT_PLL_EN 7
`define FCC_BIT_PLL_STBY 6
`define FCC_BIT_MULT_MSB 15
`define FCC_BIT_MULT_MID 5
`define FCC_BIT_MULT_LSB 4
`define FCC_BIT_IDIV_MSB 14
`define FCC_BIT_IDIV_MID 3
`define FCC_BIT_IDIV_LSB 2
`define FCC_BIT_PDIV_MSB 13
`define FCC_BIT_PDIV_MID 1
`define FCC_BIT_PDIV_LSB 0
`define FCC_MODE_2 3'h2
`define FCC_MODE_3 3'h3
`define FCC_MODE_4 3'h4
`define FCC_MODE_7 3'h7
`define FCC_MODE_CAPTURE_WAIT 2'h3
`define FCC_WD_OVERFLOW 8'hff
`define FCC_WD_MASK_0 12'h000
`define FCC_WD_MASK_1 12'h003
`define FCC_WD_MASK_2 12'h00f
`define FCC_WD_MASK_3 12'h01f
`define FCC_WD_MASK_4 12'h03f
`define FCC_WD_MASK_5 12'h0ff
`define FCC_WD_MASK_6 12'h3ff
`define FCC_WD_MASK_7 12'hfff
`endif

// File: include/fcc_pkg.sv
// types shared by the clock frequency controller and its bench
// assumes nothing beyond a SystemVerilog compiler
package fcc_pkg;

   // which oscillator feeds a divider
   typedef enum logic [1:0] {
      FCC_SRC_PLL1,
      FCC_SRC_PLL2,
      FCC_SRC_NONE
   } fcc_src_e;

   typedef enum logic {
      FCC_RUN,
      FCC_SETTLE
   } fcc_phase_e;

   // clock frequency relative to the bus clock pin: times mult, divided by div
   typedef struct packed {
      logic [3:0] mult;
      logic [2:0] div;
   } fcc_ratio_s;

   typedef struct packed {
      logic cpu_pause;
      logic int_run;
      logic per_run;
      logic pll1_on;
      logic pll1_standby;
      logic pll2_on;
      logic bus_quarter;
   } fcc_clk_ctrl_s;

endpackage

// File: logic/fcc_clock_frequency_controller.sv
// clock frequency controller: frequency control register, source selection,
// ratio decode and multiplier-change settling sequence
// assumes a classic Wishbone master on clk_i and a peripheral clock tick on clk_i
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "fcc_params.svh"
module fcc_clock_frequency_controller (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [2:0] clock_mode_i,
   input wire logic sleep_mode_i,
   input wire logic per_clk_tick_i,
   input wire logic bus_clk_i,
   input wire logic bus_clock_pin_i,
   output logic bus_clock_pin_o,
   output logic bus_clock_pin_oe_o,
   output fcc_pkg::fcc_src_e div1_src_o,
   output fcc_pkg::fcc_src_e div2_src_o,
   output fcc_pkg::fcc_ratio_s int_ratio_o,
   output fcc_pkg::fcc_ratio_s per_ratio_o,
   output fcc_pkg::fcc_clk_ctrl_s clk_ctrl_o
);

   // illegal codes fall back to times one
   function automatic logic [3:0] mult_decode(input logic [2:0] code);
      logic [3:0] r;
      r = 4'h1;
      unique case (code)
         3'b001: r = 4'h2;
         3'b100: r = 4'h3;
         3'b010: r = 4'h4;
         3'b101: r = 4'h6;
         3'b011: r = 4'h8;
         default: r = 4'h1;
      endcase
      return r;
   endfunction

   // shared by both dividers; only the peripheral one admits the sixth,
   // and codes outside the table give times one
   function automatic logic [2:0] div_decode(input logic [2:0] code, input logic six_ok);
      logic [2:0] r;
      r = 3'h1;
      unique case (code)
         3'b001: r = 3'h2;
         3'b100: r = 3'h3;
         3'b010: r = 3'h4;
         3'b101: r = six_ok ? 3'h6 : 3'h1;
         default: r = 3'h1;
      endcase
      return r;
   endfunction

   // count clock select to a prescaler mask: the count steps when all masked
   // prescaler bits are ones, so select 0 steps on every tick
   function automatic logic [11:0] wd_mask(input logic [2:0] sel);
      logic [11:0] m;
      m = `FCC_WD_MASK_0;
      unique case (sel)
         3'h0: m = `FCC_WD_MASK_0;
         3'h1: m = `FCC_WD_MASK_1;
         3'h2: m = `FCC_WD_MASK_2;
         3'h3: m = `FCC_WD_MASK_3;
         3'h4: m = `FCC_WD_MASK_4;
         3'h5: m = `FCC_WD_MASK_5;
         3'h6: m = `FCC_WD_MASK_6;
         3'h7: m = `FCC_WD_MASK_7;
      endcase
      return m;
   endfunction

   // mode strap and pin synchronisers
   logic [2:0] mode_meta;
   logic [2:0] mode_sync;
   logic [2:0] clock_mode;
   logic [1:0] mode_wait;
   logic pin_meta;
   logic pin_sync;

   // register state
   logic [15:0] freq_ctrl;
   logic [15:0] active;
   logic [10:0] settle_cfg;
   logic [7:0] wd_count;
   logic [11:0] prescale;
   fcc_pkg::fcc_phase_e phase;

   logic [15:0] next_freq_ctrl;
   logic [15:0] next_active;
   logic [10:0] next_settle_cfg;
   logic [7:0] next_wd_count;
   logic [11:0] next_prescale;
   fcc_pkg::fcc_phase_e next_phase;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_meta <= 3'h0;
         mode_sync <= 3'h0;
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
      end else if (ce_i) begin
         mode_meta <= clock_mode_i;
         mode_sync <= mode_meta;
         pin_meta <= bus_clock_pin_i;
         pin_sync <= pin_meta;
      end
   end

   // the strap is caught once, after the synchroniser has filled; the second
   // flop holds the strap only after two edges, so capture runs on the first
   // three edges after reset and later strap changes wait for the next reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_wait <= 2'h0;
         clock_mode <= 3'h0;
      end else if (ce_i && mode_wait != `FCC_MODE_CAPTURE_WAIT) begin
         mode_wait <= mode_wait + 2'h1;
         clock_mode <= mode_sync;
      end
   end

   // mode groups
   wire mode_pll1_fixed = (clock_mode <= `FCC_MODE_2) || (clock_mode == `FCC_MODE_7);
   wire mode_pll1_sw = (clock_mode == `FCC_MODE_3) || (clock_mode == `FCC_MODE_4);
   wire mode_sleep_div = (clock_mode >= `FCC_MODE_3);
   wire pll2_on = (clock_mode <= `FCC_MODE_4);

   // bus decode; byte address bits [1:0] are ignored, and a write that does
   // not cover both low lanes is acknowledged but leaves the registers alone
   wire bus_req = wb_cyc_i & wb_stb_i;
   wire bus_commit = bus_req & wb_ack_o;
   wire word_lanes = (wb_sel_i[1:0] == 2'b11);
   wire [3:0] word_adr = {wb_adr_i[3:2], 2'b00};
   wire hit_fc = (word_adr == `FCC_OFS_FREQ_CTRL);
   wire hit_status = (word_adr == `FCC_OFS_STATUS);
   wire hit_settle = (word_adr == `FCC_OFS_SETTLE_CFG);
   wire wr_ok = bus_commit & wb_we_i & word_lanes;
   wire wr_fc = wr_ok & hit_fc;
   wire wr_settle = wr_ok & hit_settle;
   wire [15:0] new_fc = wb_dat_i[15:0] & `FCC_FREQ_CTRL_WMASK;

   // field extraction
   // the codes are scattered over the register, so each three-bit code is
   // gathered msb first; the active copy is what feeds the clocks
   wire [2:0] mult_new = {new_fc[`FCC_BIT_MULT_MSB], new_fc[`FCC_BIT_MULT_MID],
                          new_fc[`FCC_BIT_MULT_LSB]};
   wire [2:0] mult_cur = {freq_ctrl[`FCC_BIT_MULT_MSB], freq_ctrl[`FCC_BIT_MULT_MID],
                          freq_ctrl[`FCC_BIT_MULT_LSB]};
   wire [2:0] mult_act = {active[`FCC_BIT_MULT_MSB], active[`FCC_BIT_MULT_MID],
                          active[`FCC_BIT_MULT_LSB]};
   wire [2:0] idiv_act = {active[`FCC_BIT_IDIV_MSB], active[`FCC_BIT_IDIV_MID],
                          active[`FCC_BIT_IDIV_LSB]};
   wire [2:0] pdiv_act = {active[`FCC_BIT_PDIV_MSB], active[`FCC_BIT_PDIV_MID],
                          active[`FCC_BIT_PDIV_LSB]};

   // settling starts on a multiplier change, or in modes 3 and 4 on both PLL bits rising together;
   // a write made while settling only updates the stored register, is applied
   // at overflow and never restarts the count
   wire running = (phase == fcc_pkg::FCC_RUN);
   wire settling = (phase == fcc_pkg::FCC_SETTLE);
   wire mult_change = (mult_new != mult_cur);
   wire pll_bits_rise = mode_pll1_sw & ~freq_ctrl[`FCC_BIT_PLL_EN]
      & ~freq_ctrl[`FCC_BIT_PLL_STBY] & new_fc[`FCC_BIT_PLL_EN] & new_fc[`FCC_BIT_PLL_STBY];
   wire start_settle = wr_fc & running & (mult_change | pll_bits_rise);

   // settling watchdog count clock from the divided peripheral clock
   // the tick comes from upstream of the peripheral clock gate, so the count
   // still advances in modes where the peripheral clock is paused
   wire [11:0] tick_mask = wd_mask(settle_cfg[10:8]);
   wire wd_step = settling & per_clk_tick_i & ((prescale & tick_mask) == tick_mask);
   wire wd_overflow = wd_step & (wd_count == `FCC_WD_OVERFLOW);

   // overflow takes the value being written in the same cycle, so a late
   // divider write is not lost
   always_comb begin
      next_freq_ctrl = wr_fc ? new_fc : freq_ctrl;
      next_settle_cfg = wr_settle ? wb_dat_i[10:0] : settle_cfg;
      next_active = active;
      if (wd_overflow) begin
         next_active = next_freq_ctrl;
      end else if (wr_fc && running && !start_settle) begin
         next_active = new_fc;
      end
   end

   // settling phase: load the count, clear the prescaler, step on ticks and
   // return to run on the step from the top count
   always_comb begin
      next_phase = phase;
      next_wd_count = wd_count;
      next_prescale = prescale;
      unique case (phase)
         fcc_pkg::FCC_RUN: begin
            if (start_settle) begin
               next_phase = fcc_pkg::FCC_SETTLE;
               next_wd_count = settle_cfg[7:0];
               next_prescale = 12'h000;
            end
         end
         fcc_pkg::FCC_SETTLE: begin
            if (per_clk_tick_i) begin
               next_prescale = prescale + 12'h001;
            end
            if (wd_step) begin
               next_wd_count = wd_count + 8'h01;
            end
            if (wd_overflow) begin
               next_phase = fcc_pkg::FCC_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         freq_ctrl <= `FCC_FREQ_CTRL_RESET;
         active <= `FCC_FREQ_CTRL_RESET;
         settle_cfg <= `FCC_SETTLE_CFG_RESET;
         phase <= fcc_pkg::FCC_RUN;
         wd_count <= 8'h00;
         prescale <= 12'h000;
      end else if (ce_i) begin
         freq_ctrl <= next_freq_ctrl;
         active <= next_active;
         settle_cfg <= next_settle_cfg;
         phase <= next_phase;
         wd_count <= next_wd_count;
         prescale <= next_prescale;
      end
   end

   // PLL1 state and divider sources
   // in modes 3 and 4 PLL1 follows the applied enable bit, so it stays off
   // from reset until software turns it on; modes 5 and 6 leave both PLLs off
   wire pll1_on = mode_pll1_fixed | (mode_pll1_sw & active[`FCC_BIT_PLL_EN]);
   wire pll1_standby = mode_pll1_sw & freq_ctrl[`FCC_BIT_PLL_STBY];

   wire fcc_pkg::fcc_src_e div1_src = pll1_on ? fcc_pkg::FCC_SRC_PLL1 :
      (pll2_on ? fcc_pkg::FCC_SRC_PLL2 : fcc_pkg::FCC_SRC_NONE);
   wire fcc_pkg::fcc_src_e div2_src = mode_pll1_fixed ? fcc_pkg::FCC_SRC_PLL1 :
      ((mode_pll1_sw & pll2_on) ? fcc_pkg::FCC_SRC_PLL2 : fcc_pkg::FCC_SRC_NONE);

   // ratios relative to the bus clock pin
   // with PLL1 off the internal clock runs at the pin rate whatever the divider holds
   wire [3:0] mult_val = mult_decode(mult_act);
   wire [2:0] idiv_val = div_decode(idiv_act, 1'b0);
   wire [2:0] pdiv_val = div_decode(pdiv_act, 1'b1);

   fcc_pkg::fcc_ratio_s int_ratio;
   fcc_pkg::fcc_ratio_s per_ratio;
   assign int_ratio.mult = pll1_on ? mult_val : 4'h1;
   assign int_ratio.div = pll1_on ? idiv_val : 3'h1;
   assign per_ratio.mult = mode_pll1_fixed ? mult_val : 4'h1;
   assign per_ratio.div = pdiv_val;

   // clock run controls; the peripheral clock only stops where PLL1 feeds it
   // the bus clock drops to a quarter only in sleep and only in modes 3 to 7
   fcc_pkg::fcc_clk_ctrl_s clk_ctrl;
   assign clk_ctrl.cpu_pause = settling;
   assign clk_ctrl.int_run = ~settling;
   assign clk_ctrl.per_run = ~(settling & mode_pll1_fixed);
   assign clk_ctrl.pll1_on = pll1_on;
   assign clk_ctrl.pll1_standby = pll1_standby;
   assign clk_ctrl.pll2_on = pll2_on;
   assign clk_ctrl.bus_quarter = mode_sleep_div & sleep_mode_i
      & freq_ctrl[`FCC_BIT_SLEEP_DIV];

   // the clock controls leave through flops so that dividers and gates
   // downstream see clean levels; they lag the register by one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div1_src_o <= fcc_pkg::FCC_SRC_NONE;
         div2_src_o <= fcc_pkg::FCC_SRC_NONE;
         int_ratio_o <= '0;
         per_ratio_o <= '0;
         clk_ctrl_o <= '0;
      end else if (ce_i) begin
         div1_src_o <= div1_src;
         div2_src_o <= div2_src;
         int_ratio_o <= int_ratio;
         per_ratio_o <= per_ratio;
         clk_ctrl_o <= clk_ctrl;
      end
   end

   // bus clock pin: driven unless mode 7, low while output is disabled;
   // the clock path is not registered and is not paused by settling
   wire clk_out_en = freq_ctrl[`FCC_BIT_CLK_OUT_EN];
   assign bus_clock_pin_oe_o = (clock_mode != `FCC_MODE_7);
   assign bus_clock_pin_o = bus_clock_pin_oe_o & clk_out_en & bus_clk_i;

   // register read data
   // unmapped words and the unused high half read as zero
   wire [31:0] status_word = {16'h0000, wd_count, 1'b0, pin_sync, clock_mode,
                              pll1_standby, pll1_on, settling};
   wire [31:0] read_word = hit_fc ? {16'h0000, freq_ctrl} :
      hit_status ? status_word :
      hit_settle ? {21'h000000, settle_cfg} : 32'h00000000;

   // one wait state: data and ack registered, ack dropped after one cycle
   // a request still held after ack is answered again two cycles later, so
   // the master must drop cyc and stb for a cycle between transfers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else if (ce_i) begin
         wb_ack_o <= bus_req & ~wb_ack_o;
         if (bus_req && !wb_ack_o && !wb_we_i) begin
            wb_dat_o <= read_word;
         end
      end
   end

endmodule

// File: verif/fcc_checker.sv
// port assertions for the clock frequency controller
// assumes binding onto fcc_clock_frequency_controller; ce_i drops only while idle
`timescale 1ns/1ps
module fcc_checker (
   input logic clk_i,
   input logic rst_i,
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic sleep_mode_i,
   input logic per_clk_tick_i,
   input logic bus_clk_i,
   input logic [31:0] wb_dat_o,
   input logic wb_ack_o,
   input logic bus_clock_pin_o,
   input logic bus_clock_pin_oe_o,
   input fcc_pkg::fcc_src_e div1_src_o,
   input fcc_pkg::fcc_ratio_s int_ratio_o,
   input fcc_pkg::fcc_clk_ctrl_s clk_ctrl_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_has_request: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
      else $error("upper read bits not zero");
   a_pin_fixed_level: assert property (bus_clock_pin_o |-> bus_clk_i && bus_clock_pin_oe_o)
      else $error("pin driven while fixed");
   a_div1_from_pll1: assert property (clk_ctrl_o.pll1_on |-> div1_src_o == fcc_pkg::FCC_SRC_PLL1)
      else $error("divider 1 not on pll1");
   a_div1_from_pll2: assert property (!clk_ctrl_o.pll1_on && clk_ctrl_o.pll2_on
      |-> div1_src_o == fcc_pkg::FCC_SRC_PLL2)
      else $error("divider 1 not on pll2");
   a_int_bypass_ratio: assert property (!clk_ctrl_o.pll1_on && clk_ctrl_o.pll2_on
      |-> int_ratio_o == {4'h1, 3'h1})
      else $error("internal ratio not pin rate");
   a_pause_stops_int: assert property (clk_ctrl_o.cpu_pause |-> !clk_ctrl_o.int_run)
      else $error("internal clock runs in pause");
   a_resume_on_tick: assert property ($fell(clk_ctrl_o.cpu_pause) |->
      $past(per_clk_tick_i) || $past(per_clk_tick_i, 2) || $past(per_clk_tick_i, 3))
      else $error("resume without count step");
   a_quarter_in_sleep: assert property (clk_ctrl_o.bus_quarter |-> $past(sleep_mode_i))
      else $error("quarter bus clock outside sleep");
   c_pause: cover property ($rose(clk_ctrl_o.cpu_pause));
   c_quarter: cover property (clk_ctrl_o.bus_quarter);
   c_input_pin: cover property (wb_ack_o && !bus_clock_pin_oe_o);
endmodule

// File: verif/fcc_testbench.sv
// self-checking bench for the clock frequency controller
// assumes package, design and fcc_checker compiled before it
`timescale 1ns/1ps
module testbench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [2:0] clock_mode_i = 3'h0;
   logic sleep_mode_i = 1'b0;
   logic per_clk_tick_i = 1'b0;
   logic bus_clk_i = 1'b0;
   logic bus_clock_pin_i = 1'b0;
   logic bus_clock_pin_o;
   logic bus_clock_pin_oe_o;
   fcc_pkg::fcc_src_e div1_src_o;
   fcc_pkg::fcc_src_e div2_src_o;
   fcc_pkg::fcc_ratio_s int_ratio_o;
   fcc_pkg::fcc_ratio_s per_ratio_o;
   fcc_pkg::fcc_clk_ctrl_s clk_ctrl_o;
   int fails = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [31:0] q;
   // permitted mode 0 settings with their internal and peripheral ratios
   logic [15:0] fword [9] = '{16'h0100, 16'h0111, 16'h0115, 16'h0116, 16'ha100, 16'he101,
      16'h0122, 16'h012a, 16'ha111};
   logic [6:0] iexp [9] = '{7'h09, 7'h11, 7'h12, 7'h12, 7'h19, 7'h1b, 7'h21, 7'h24, 7'h31};
   logic [6:0] pexp [9] = '{7'h09, 7'h12, 7'h12, 7'h14, 7'h1b, 7'h1e, 7'h24, 7'h24, 7'h36};

   fcc_clock_frequency_controller DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .clock_mode_i(clock_mode_i), .sleep_mode_i(sleep_mode_i),
      .per_clk_tick_i(per_clk_tick_i), .bus_clk_i(bus_clk_i),
      .bus_clock_pin_i(bus_clock_pin_i), .bus_clock_pin_o(bus_clock_pin_o),
      .bus_clock_pin_oe_o(bus_clock_pin_oe_o), .div1_src_o(div1_src_o),
      .div2_src_o(div2_src_o), .int_ratio_o(int_ratio_o), .per_ratio_o(per_ratio_o),
      .clk_ctrl_o(clk_ctrl_o));

   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      bus_clk_i <= ~bus_clk_i;
      cycles++;
      if (cycles > 20000) begin
         fails++;
         $display("mismatch at %0t: timeout", $time);
         end_of_test();
      end
   end

   task automatic end_of_test();
      if (fails == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one classic cycle; request held until ack is sampled high
   task automatic wb(input logic we, input logic [3:0] a, input logic [3:0] s,
         input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      chk({31'h0, wb_ack_o}, 32'h1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      wb(1'b1, a, 4'hf, d);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      wb(1'b0, a, 4'hf, 32'h0);
      chk(q, e);
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         per_clk_tick_i <= 1'b1;
         @(posedge clk_i);
         per_clk_tick_i <= 1'b0;
         repeat (2) @(posedge clk_i);
      end
   endtask
   task automatic settle();
      repeat (3) @(posedge clk_i);
   endtask
   task automatic reset(input logic [2:0] m);
      clock_mode_i <= m;
      rst_i <= 1'b1;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (5) @(posedge clk_i);
   endtask
   task automatic outs(input logic [1:0] d1, input logic [1:0] d2, input logic [6:0] ir,
         input logic [6:0] pr, input logic [6:0] cc);
      chk({30'h0, div1_src_o}, {30'h0, d1});
      chk({30'h0, div2_src_o}, {30'h0, d2});
      chk({25'h0, int_ratio_o}, {25'h0, ir});
      chk({25'h0, per_ratio_o}, {25'h0, pr});
      chk({25'h0, clk_ctrl_o}, {25'h0, cc});
   endtask
   // pin must follow the bus clock only when output is enabled
   task automatic pin(input logic en);
      repeat (4) begin
         @(negedge clk_i);
         chk({31'h0, bus_clock_pin_o}, {31'h0, en & bus_clk_i});
      end
      @(posedge clk_i);
   endtask

   initial begin
      reset(3'h0);
      rd(4'h0, 32'h0102);
      rd(4'hc, 32'h0);
      outs(2'h0, 2'h0, 7'h09, 7'h0c, 7'h3a);
      wb(1'b1, 4'h0, 4'hc, 32'h0);
      rd(4'h0, 32'h0102);
      wr(4'h0, 32'h1d02);
      rd(4'h0, 32'h0502);
      wr(4'h8, 32'hfe);
      rd(4'h8, 32'hfe);
      wr(4'h0, 32'h0111);
      settle();
      outs(2'h0, 2'h0, 7'h09, 7'h0c, 7'h4a);
      // clock enable low: ticks must not advance the count
      ce_i <= 1'b0;
      tick(2);
      ce_i <= 1'b1;
      tick(1);
      outs(2'h0, 2'h0, 7'h09, 7'h0c, 7'h4a);
      tick(1);
      settle();
      outs(2'h0, 2'h0, {4'h2, 3'h1}, {4'h2, 3'h2}, 7'h3a);
      rd(4'h4, 32'h2);
      wr(4'h0, 32'h0112);
      settle();
      outs(2'h0, 2'h0, {4'h2, 3'h1}, {4'h2, 3'h4}, 7'h3a);
      for (int i = 0; i < 9; i++) begin
         wr(4'h0, {16'h0, fword[i]});
         tick(2);
         settle();
         outs(2'h0, 2'h0, iexp[i], pexp[i], 7'h3a);
      end
      sleep_mode_i <= 1'b1;
      reset(3'h3);
      outs(2'h1, 2'h1, 7'h09, 7'h0c, 7'h32);
      wr(4'h0, 32'h0302);
      settle();
      chk({25'h0, clk_ctrl_o}, 32'h33);
      wr(4'h0, 32'h0202);
      pin(1'b0);
      wr(4'h0, 32'h0302);
      pin(1'b1);
      wr(4'h0, 32'h0140);
      settle();
      chk({25'h0, clk_ctrl_o}, 32'h36);
      sleep_mode_i <= 1'b0;
      wr(4'h8, 32'hfe);
      wr(4'h0, 32'h01d0);
      settle();
      outs(2'h1, 2'h1, 7'h09, 7'h09, 7'h56);
      tick(2);
      settle();
      outs(2'h0, 2'h1, {4'h2, 3'h1}, 7'h09, 7'h3e);
      wr(4'h0, 32'h01f0);
      tick(2);
      settle();
      outs(2'h0, 2'h1, 7'h41, 7'h09, 7'h3e);
      reset(3'h7);
      outs(2'h0, 2'h0, 7'h09, 7'h0c, 7'h38);
      chk({31'h0, bus_clock_pin_oe_o}, 32'h0);
      bus_clock_pin_i <= 1'b1;
      settle();
      rd(4'h4, 32'h7a);
      end_of_test();
   end
endmodule

bind fcc_clock_frequency_controller fcc_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .sleep_mode_i(sleep_mode_i),
   .per_clk_tick_i(per_clk_tick_i), .bus_clk_i(bus_clk_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .bus_clock_pin_o(bus_clock_pin_o),
   .bus_clock_pin_oe_o(bus_clock_pin_oe_o), .div1_src_o(div1_src_o),
   .int_ratio_o(int_ratio_o), .clk_ctrl_o(clk_ctrl_o));
